// [src/three_phase_bridge_control.sv]
// control logic of a three-phase half-bridge power stage
`timescale 1ns/10ps
`default_nettype none
module three_phase_bridge_control
  import bridge_pkg::*;
#(
  parameter int unsigned WAKE_CYC     = WAKE_CYCLES,
  parameter int unsigned RETRY_CYC    = RETRY_CYCLES,
  parameter int unsigned DEGLITCH_CYC = DEGLITCH_CYCLES,
  parameter bit          SPLIT_INPUTS = 1'b0
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_n_i,
  input  wire logic [PHASE_COUNT-1:0] phase_enable_i,
  input  wire logic [PHASE_COUNT-1:0] phase_drive_level_i,
  input  wire logic [PHASE_COUNT-1:0] high_switch_request_i,
  input  wire logic [PHASE_COUNT-1:0] low_switch_request_i,
  input  wire logic                   sleep_request_n_i,
  input  wire supply_mon_t            supply_mon_i,
  input  wire logic [PHASE_COUNT-1:0] phase_below_gnd_i,
  input  wire logic [PHASE_COUNT-1:0] phase_above_vin_i,
  input  wire logic [PHASE_COUNT-1:0] current_near_zero_i,
  input  wire logic [PHASE_COUNT-1:0] high_overcurrent_i,
  input  wire logic [PHASE_COUNT-1:0] low_overcurrent_i,
  output var  phase_gate_t [PHASE_COUNT-1:0] gate_o,
  output var  logic                   fault_flag_n_o,
  output var  logic                   fault_flag_n_oe_o,
  output var  logic                   awake_o
);
  localparam int unsigned SYNC_W = 6 * PHASE_COUNT + 4;

  if (WAKE_CYC < 1 || RETRY_CYC < 1 || DEGLITCH_CYC < 1)
  begin : g_bad_count
    $error("counts must be at least 1");
  end
  if (WAKE_CYC >= (1 << COUNT_W) || RETRY_CYC >= (1 << COUNT_W))
  begin : g_bad_width
    $error("count too wide");
  end

  // every pin and comparator is asynchronous to clk_sys_i
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] syn;
  assign raw_in = {phase_enable_i, phase_drive_level_i, high_switch_request_i,
                   low_switch_request_i, phase_below_gnd_i, phase_above_vin_i,
                   sleep_request_n_i, supply_mon_i};

  input_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .async_i   (raw_in),
    .sync_o    (syn)
  );

  logic [PHASE_COUNT-1:0] en_s, lvl_s, hreq_s, lreq_s, below_s, above_s;
  logic                   sleep_n_s;
  supply_mon_t            mon_s;
  assign {en_s, lvl_s, hreq_s, lreq_s, below_s, above_s, sleep_n_s, mon_s} = syn;

  // near-zero and over-current comparators are fast analogue signals; the
  // deglitch counter filters only the over-current ones, so all of them also pass a synchroniser
  logic [3*PHASE_COUNT-1:0] fast_s;
  input_sync #(.WIDTH(3 * PHASE_COUNT)) u_sync_fast (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .async_i   ({current_near_zero_i, high_overcurrent_i, low_overcurrent_i}),
    .sync_o    (fast_s)
  );
  logic [PHASE_COUNT-1:0] nz_s, hoc_s, loc_s;
  assign {nz_s, hoc_s, loc_s} = fast_s;

  // state and counters
  bridge_state_t        state_q, state_d;
  logic [COUNT_W-1:0]   timer_q, timer_d;
  logic [COUNT_W-1:0]   oc_cnt_q, oc_cnt_d;
  logic                 any_oc;
  logic                 oc_trip;
  logic                 powered;

  assign any_oc  = |(hoc_s | loc_s);
  assign oc_trip = any_oc && (oc_cnt_q >= COUNT_W'(DEGLITCH_CYC - 1));
  assign powered = sleep_n_s && !mon_s.undervolt;

  always_comb
  begin
    state_d  = state_q;
    timer_d  = timer_q;
    oc_cnt_d = (any_oc && state_q == ST_RUN) ? oc_cnt_q + COUNT_W'(1) : '0;
    case (state_q)
      ST_ASLEEP:
      begin
        timer_d = '0;
        if (powered)
        begin
          state_d = ST_WAKING;
        end
      end
      ST_WAKING:
      begin
        timer_d = timer_q + COUNT_W'(1);
        if (timer_q >= COUNT_W'(WAKE_CYC - 1))
        begin
          state_d = ST_RUN;
          timer_d = '0;
        end
      end
      ST_RUN:
      begin
        if (oc_trip)
        begin
          state_d  = ST_OC_RETRY;
          timer_d  = '0;
          oc_cnt_d = '0;
        end
      end
      ST_OC_RETRY:
      begin
        timer_d = timer_q + COUNT_W'(1);
        if (timer_q >= COUNT_W'(RETRY_CYC - 1))
        begin
          state_d = ST_RUN;
          timer_d = '0;
        end
      end
      default:
      begin
        state_d = ST_ASLEEP;
        timer_d = '0;
      end
    endcase
    if (!powered)
    begin
      state_d  = ST_ASLEEP;
      timer_d  = '0;
      oc_cnt_d = '0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q  <= ST_ASLEEP;
      timer_q  <= '0;
      oc_cnt_q <= '0;
    end
    else
    begin
      state_q  <= state_d;
      timer_q  <= timer_d;
      oc_cnt_q <= oc_cnt_d;
    end
  end

  // gate decisions per phase
  phase_gate_t [PHASE_COUNT-1:0] gate_d;
  logic [PHASE_COUNT-1:0]        rect_lo_q, rect_lo_d, rect_hi_q, rect_hi_d;
  logic                          bridge_ok;
  logic                          rect_ok;

  // over-voltage and over-temperature hold every switch off, rectification too
  assign bridge_ok = (state_q == ST_RUN) && !mon_s.overvolt && !mon_s.overtemp;
  assign rect_ok   = (state_q == ST_RUN || state_q == ST_OC_RETRY)
                     && !mon_s.overvolt && !mon_s.overtemp;

  genvar gi;
  generate
    for (gi = 0; gi < PHASE_COUNT; gi++)
    begin : g_phase
      logic cmd_hi, cmd_lo;
      always_comb
      begin
        if (SPLIT_INPUTS)
        begin
          cmd_hi = hreq_s[gi] && !lreq_s[gi];
          cmd_lo = lreq_s[gi] && !hreq_s[gi];
        end
        else
        begin
          cmd_hi = en_s[gi] && lvl_s[gi];
          cmd_lo = en_s[gi] && !lvl_s[gi];
        end
        if (!bridge_ok)
        begin
          cmd_hi = 1'b0;
          cmd_lo = 1'b0;
        end
        // rectification holds until current near zero or opposite switch asked
        rect_lo_d[gi] = rect_ok && !cmd_hi && !nz_s[gi]
                        && (rect_lo_q[gi] || (!cmd_lo && below_s[gi]));
        rect_hi_d[gi] = rect_ok && !cmd_lo && !nz_s[gi] && !rect_lo_d[gi]
                        && (rect_hi_q[gi] || (!cmd_hi && above_s[gi]));
        gate_d[gi].high_on = cmd_hi || rect_hi_d[gi];
        gate_d[gi].low_on  = cmd_lo || rect_lo_d[gi];
      end
    end
  endgenerate

  logic fault_d;
  // flag follows the live causes, so it drops when retry ends or die cools
  assign fault_d = (state_q == ST_OC_RETRY && state_d == ST_OC_RETRY)
                   || (state_d == ST_OC_RETRY)
                   || (powered && mon_s.overtemp);

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      gate_o            <= '0;
      rect_lo_q         <= '0;
      rect_hi_q         <= '0;
      fault_flag_n_o    <= 1'b0;
      fault_flag_n_oe_o <= 1'b0;
      awake_o           <= 1'b0;
    end
    else
    begin
      gate_o            <= gate_d;
      rect_lo_q         <= rect_lo_d;
      rect_hi_q         <= rect_hi_d;
      fault_flag_n_o    <= 1'b0;
      fault_flag_n_oe_o <= fault_d;
      awake_o           <= (state_d == ST_RUN);
    end
  end

  // assertions
  property p_sleep_off;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_q == ST_ASLEEP) |=> (gate_o == '0);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("switch on while asleep");

  property p_wake_delay;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_q == ST_ASLEEP && state_d == ST_WAKING) |=> !awake_o [*8];
  endproperty
  a_wake_delay: assert property (p_wake_delay) else $error("awake too early");

  property p_ov_off;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    mon_s.overvolt && !mon_s.overtemp && (state_d != ST_OC_RETRY)
      |=> (gate_o == '0) && !fault_flag_n_oe_o;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("over-voltage not handled");

  property p_ot_flag;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (powered && mon_s.overtemp) |=> fault_flag_n_oe_o && (gate_o == '0);
  endproperty
  a_ot_flag: assert property (p_ot_flag) else $error("over-temperature not flagged");

  sequence s_oc_trip;
    state_q == ST_RUN && oc_trip && powered;
  endsequence
  property p_oc_shut;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    s_oc_trip |=> (state_q == ST_OC_RETRY) && fault_flag_n_oe_o;
  endproperty
  a_oc_shut: assert property (p_oc_shut) else $error("over-current not shut down");

  property p_retry_hold;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_q == ST_OC_RETRY && timer_q < COUNT_W'(RETRY_CYC - 1) && powered)
      |=> (state_q == ST_OC_RETRY);
  endproperty
  a_retry_hold: assert property (p_retry_hold) else $error("retry ended early");

  property p_fault_release;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (state_q == ST_RUN && !mon_s.overtemp && !oc_trip && powered)
      |=> !fault_flag_n_oe_o;
  endproperty
  a_fault_release: assert property (p_fault_release) else $error("fault held");

  property p_no_shoot;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    ##1 1'b1 |-> (gate_o[0] != 2'h3) && (gate_o[1] != 2'h3) && (gate_o[2] != 2'h3);
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("both switches on");
endmodule
`default_nettype wire

// [src/bridge_pkg.sv]
// constants and carrier types for the three-phase bridge control
`default_nettype none
package bridge_pkg;
  localparam int unsigned CLK_FREQ_HZ   = 40000000;
  localparam int unsigned PHASE_COUNT   = 3;
  localparam int unsigned WAKE_TIME_US  = 1000;
  localparam int unsigned RETRY_TIME_US = 2000;
  localparam int unsigned DEGLITCH_NS   = 400;
  localparam int unsigned WAKE_CYCLES   = (WAKE_TIME_US * (CLK_FREQ_HZ / 1000000));
  localparam int unsigned RETRY_CYCLES  = (RETRY_TIME_US * (CLK_FREQ_HZ / 1000000));
  localparam int unsigned DEGLITCH_CYCLES = (DEGLITCH_NS * (CLK_FREQ_HZ / 1000000)) / 1000;
  localparam int unsigned COUNT_W       = 17;

  // per-phase switch commands
  typedef struct packed {
    logic high_on;
    logic low_on;
  } phase_gate_t;

  // analogue monitors, already comparator outputs
  typedef struct packed {
    logic undervolt;
    logic overvolt;
    logic overtemp;
  } supply_mon_t;

  typedef enum logic [1:0] {
    ST_ASLEEP,
    ST_WAKING,
    ST_RUN,
    ST_OC_RETRY
  } bridge_state_t;
endpackage
`default_nettype wire

// [src/input_sync.sv]
// two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module input_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("input_sync width must be positive");
  end

  always_comb
  begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_o <= sync_d;
    end
  end
endmodule
`default_nettype wire

// [verif/motor_ctrl_model.sv]
// behavioural motor controller that drives the bridge phase inputs
`timescale 1ns/10ps
`default_nettype none
module motor_ctrl_model
  import bridge_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   awake_i,
  output var  logic [PHASE_COUNT-1:0] phase_enable_o,
  output var  logic [PHASE_COUNT-1:0] phase_drive_level_o,
  output var  logic [PHASE_COUNT-1:0] high_switch_request_o,
  output var  logic [PHASE_COUNT-1:0] low_switch_request_o,
  output var  logic                   sleep_request_n_o
);
  initial
  begin
    phase_enable_o = 3'h0;
    phase_drive_level_o = 3'h0;
    high_switch_request_o = 3'h0;
    low_switch_request_o = 3'h0;
    sleep_request_n_o = 1'b0;
  end

  // levels only, no handshake: change right after the rising edge
  task automatic drive(input logic [2:0] en, input logic [2:0] lvl,
                       input logic [2:0] hs, input logic [2:0] ls);
    @(posedge clk_sys_i);
    phase_enable_o <= en;
    phase_drive_level_o <= lvl;
    high_switch_request_o <= hs;
    low_switch_request_o <= ls;
  endtask

  task automatic set_sleep_n(input logic s);
    @(posedge clk_sys_i);
    sleep_request_n_o <= s;
  endtask

  // no output change is counted on before the bridge reports awake
  task automatic wait_awake(output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 60 && !ok; n++)
    begin
      @(negedge clk_sys_i);
      ok = (awake_i === 1'b1);
    end
  endtask
endmodule
`default_nettype wire

// [verif/three_phase_bridge_control_tb_top.sv]
// self-checking bench for the three-phase bridge control
`timescale 1ns/10ps
`default_nettype none
module three_phase_bridge_control_tb_top
  import bridge_pkg::*;
;
  localparam int unsigned WAKE_T     = 20;
  localparam int unsigned RETRY_T    = 30;
  localparam int unsigned DEGLITCH_T = 2;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  supply_mon_t       mon;
  logic [2:0]        blw, abv, nz, hoc, loc;
  logic [2:0]        en, lvl, hs, ls;
  phase_gate_t [2:0] ga, gb;
  logic              flt, oe, awk, sl_n, fltb, oeb, awkb;
  int                bad_count = 0;
  int                n_checks = 0;

  always #12.5 clk = ~clk;

  motor_ctrl_model u_motor_ctrl_model (.clk_sys_i(clk), .awake_i(awk),
    .phase_enable_o(en), .phase_drive_level_o(lvl), .high_switch_request_o(hs),
    .low_switch_request_o(ls), .sleep_request_n_o(sl_n));

  // short counts keep the run small; expectations follow these values
  // first instance keeps the default enable and level input variant
  three_phase_bridge_control #(.WAKE_CYC(WAKE_T), .RETRY_CYC(RETRY_T),
    .DEGLITCH_CYC(DEGLITCH_T)) u_three_phase_bridge_control (.clk_sys_i(clk),
    .reset_n_i(rst_n), .phase_enable_i(en), .phase_drive_level_i(lvl),
    .high_switch_request_i(hs), .low_switch_request_i(ls), .sleep_request_n_i(sl_n),
    .supply_mon_i(mon), .phase_below_gnd_i(blw), .phase_above_vin_i(abv),
    .current_near_zero_i(nz), .high_overcurrent_i(hoc), .low_overcurrent_i(loc),
    .gate_o(ga), .fault_flag_n_o(flt), .fault_flag_n_oe_o(oe), .awake_o(awk));

  three_phase_bridge_control #(.WAKE_CYC(WAKE_T), .RETRY_CYC(RETRY_T),
    .DEGLITCH_CYC(DEGLITCH_T), .SPLIT_INPUTS(1'b1)) u_three_phase_bridge_control_split (
    .clk_sys_i(clk),
    .reset_n_i(rst_n), .phase_enable_i(en), .phase_drive_level_i(lvl),
    .high_switch_request_i(hs), .low_switch_request_i(ls), .sleep_request_n_i(sl_n),
    .supply_mon_i(mon), .phase_below_gnd_i(blw), .phase_above_vin_i(abv),
    .current_near_zero_i(nz), .high_overcurrent_i(hoc), .low_overcurrent_i(loc),
    .gate_o(gb), .fault_flag_n_o(fltb), .fault_flag_n_oe_o(oeb), .awake_o(awkb));

  task automatic chk(input string nm, input logic [5:0] e, input logic [5:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chkf(input logic e_oe);
    chk("fault_flag", {4'h0, e_oe, 1'b0}, {4'h0, oe, flt});
    chk("fault_flag_split", {4'h0, e_oe, 1'b0}, {4'h0, oeb, fltb});
  endtask

  task automatic sett(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic conclude;
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic t_wake;
    logic ok;
    u_motor_ctrl_model.set_sleep_n(1'b1);
    u_motor_ctrl_model.drive(3'h7, 3'h7, 3'h0, 3'h0);
    sett(10);
    chk("gate_waking", 6'h00, ga);
    chk("awake_early", 6'h00, {5'h00, awk});
    u_motor_ctrl_model.wait_awake(ok);
    chk("awake", 6'h01, {5'h00, ok});
    chk("awake_split", 6'h01, {5'h00, awkb});
    sett(4);
    chk("gate_run", 6'h2a, ga);
  endtask

  task automatic t_logic;
    u_motor_ctrl_model.drive(3'h6, 3'h3, 3'h6, 3'h3);
    sett(4);
    chk("gate_std", 6'h18, ga);
    chk("gate_split", 6'h21, gb);
    u_motor_ctrl_model.drive(3'h1, 3'h0, 3'h0, 3'h0);
    sett(4);
    chk("gate_std", 6'h01, ga);
    chk("gate_split", 6'h00, gb);
  endtask

  task automatic t_rect;
    u_motor_ctrl_model.drive(3'h0, 3'h0, 3'h0, 3'h0);
    @(posedge clk);
    blw <= 3'h2;
    abv <= 3'h1;
    sett(4);
    chk("gate_rect", 6'h06, ga);
    @(posedge clk);
    nz <= 3'h3;
    sett(4);
    chk("gate_rect_end", 6'h00, ga);
    @(posedge clk);
    blw <= 3'h0;
    abv <= 3'h0;
    nz <= 3'h0;
  endtask

  // a one-cycle glitch must not trip; a held one must
  task automatic t_oc(input logic hi);
    int w;
    u_motor_ctrl_model.drive(3'h7, 3'h7, 3'h0, 3'h0);
    @(posedge clk);
    if (hi) hoc <= 3'h1; else loc <= 3'h2;
    @(posedge clk);
    hoc <= 3'h0;
    loc <= 3'h0;
    sett(5);
    chkf(1'b0);
    chk("gate_glitch", 6'h2a, ga);
    @(posedge clk);
    if (hi) hoc <= 3'h1; else loc <= 3'h2;
    repeat (4) @(posedge clk);
    hoc <= 3'h0;
    loc <= 3'h0;
    blw <= 3'h4;
    sett(3);
    chk("gate_oc_rect", 6'h10, ga);
    chkf(1'b1);
    // the rectifying low switch only lets go once current is near zero
    @(posedge clk);
    blw <= 3'h0;
    nz <= 3'h4;
    sett(6);
    chk("gate_oc", 6'h00, ga);
    chkf(1'b1);
    // shutdown began ten cycles before this point
    w = 0;
    while (w < 40 && oe !== 1'b0)
    begin
      @(negedge clk);
      w++;
    end
    chk("retry_len", 6'(RETRY_T - 10), 6'(w));
    sett(4);
    chk("gate_retry", 6'h2a, ga);
    chkf(1'b0);
    @(posedge clk);
    nz <= 3'h0;
  endtask

  task automatic t_prot;
    logic ok;
    @(posedge clk);
    mon.overtemp <= 1'b1;
    sett(4);
    chk("gate_hot", 6'h00, ga);
    chkf(1'b1);
    @(posedge clk);
    mon.overtemp <= 1'b0;
    sett(4);
    chk("gate_cool", 6'h2a, ga);
    chkf(1'b0);
    @(posedge clk);
    mon.overvolt <= 1'b1;
    sett(4);
    chk("gate_ovp", 6'h00, ga);
    chkf(1'b0);
    @(posedge clk);
    mon.overvolt <= 1'b0;
    sett(4);
    chk("gate_ovp_end", 6'h2a, ga);
    @(posedge clk);
    mon.undervolt <= 1'b1;
    sett(4);
    chk("gate_uvlo", 6'h00, ga);
    chk("awake_uvlo", 6'h00, {5'h00, awk});
    @(posedge clk);
    mon.undervolt <= 1'b0;
    u_motor_ctrl_model.wait_awake(ok);
    chk("awake_uvlo_end", 6'h01, {5'h00, ok});
    sett(4);
    chk("gate_uvlo_end", 6'h2a, ga);
    u_motor_ctrl_model.set_sleep_n(1'b0);
    u_motor_ctrl_model.drive(3'h1, 3'h0, 3'h0, 3'h0);
    sett(4);
    chk("gate_sleep", 6'h00, ga);
    chk("awake_sleep", 6'h00, {5'h00, awk});
  endtask

  initial
  begin
    mon <= '0;
    blw <= 3'h0;
    abv <= 3'h0;
    nz <= 3'h0;
    hoc <= 3'h0;
    loc <= 3'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_wake();
    t_logic();
    t_rect();
    t_oc(1'b1);
    t_oc(1'b0);
    t_prot();
    conclude();
  end

  // the tests need well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
